// File: pkg/spm_pkg.sv
// spm_pkg: constants, opcodes and carriers for the sequential byte program logic
package spm_pkg;

	localparam int CLK_PERIOD_NS        = 10;
	localparam int BYTE_PROGRAM_TIME_NS = 10000;
	localparam int BYTE_PROGRAM_CYCLES  =
		(BYTE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W              = 16;

	localparam logic [23:0] ARRAY_LAST_ADDR = 24'h03FFFF;
	localparam logic [23:0] ADDR_STEP       = 24'h000001;
	localparam logic [2:0]  BIT_LAST        = 3'h7;
	localparam logic [2:0]  BIT_STEP        = 3'h1;
	localparam logic [1:0]  ADDR_BYTE_LAST  = 2'h2;
	localparam logic [1:0]  IDX_STEP        = 2'h1;
	localparam logic [1:0]  IDX_DEV         = 2'h1;
	localparam logic [1:0]  IDX_MFG         = 2'h0;
	localparam logic [15:0] TIMER_LAST      = 16'h0001;
	localparam logic [15:0] TIMER_STEP      = 16'h0001;

	// status register one layout
	localparam int SR1_BUSY_BIT = 0;
	localparam int SR1_WEL_BIT  = 1;

	// identification bytes, values arbitrary
	localparam logic [7:0] MFG_ID_DEFAULT = 8'h5A;
	localparam logic [7:0] DEV_ID_DEFAULT = 8'hC3;

	localparam logic [7:0] OP_SEQ_A     = 8'hAD;
	localparam logic [7:0] OP_SEQ_B     = 8'hAF;
	localparam logic [7:0] OP_WREN      = 8'h06;
	localparam logic [7:0] OP_WRDI      = 8'h04;
	localparam logic [7:0] OP_RDSR1     = 8'h05;
	localparam logic [7:0] OP_RDSR2     = 8'h35;
	localparam logic [7:0] OP_RDSR3     = 8'h15;
	localparam logic [7:0] OP_RDSR_IND  = 8'h65;
	localparam logic [7:0] OP_ID_JEDEC  = 8'h9F;
	localparam logic [7:0] OP_ID_MFG    = 8'h90;
	localparam logic [7:0] OP_ID_QUAD   = 8'h94;
	localparam logic [7:0] OP_TERMINATE = 8'hF0;
	localparam logic [7:0] OP_RESET_EN  = 8'h66;
	localparam logic [7:0] OP_RESET     = 8'h99;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
	} spm_pins_t;

	localparam spm_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};

	typedef struct packed {
		logic [23:0] addr;
		logic [7:0]  data;
	} spm_prog_t;

	typedef enum {PH_OPCODE, PH_ADDR, PH_DATA, PH_READ, PH_DROP} spm_phase_t;

endpackage : spm_pkg

// File: rtl/spm_pin_sync.sv
// spm_pin_sync: two-stage pin synchroniser with edge detection
`timescale 1ns/1ns
`default_nettype none
module spm_pin_sync (
	// clock and reset
	input  wire logic               clock_i,
	input  wire logic               reset_i,
	// raw pins
	input  wire spm_pkg::spm_pins_t pins_i,
	// synchronised pins and edges
	output spm_pkg::spm_pins_t      pins_o,
	output logic                    sck_rise_o,
	output logic                    sck_fall_o,
	output logic                    cs_assert_o,
	output logic                    cs_release_o
);
	import spm_pkg::*;

	spm_pins_t meta;
	spm_pins_t sync;
	spm_pins_t prev;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			meta <= PINS_IDLE;
			sync <= PINS_IDLE;
			prev <= PINS_IDLE;
		end else begin
			meta <= pins_i;
			sync <= meta;
			prev <= sync;
		end
	end

	assign pins_o       = sync;
	assign sck_rise_o   = sync.sck && !prev.sck;
	assign sck_fall_o   = !sync.sck && prev.sck;
	assign cs_assert_o  = !sync.cs_n && prev.cs_n;
	assign cs_release_o = sync.cs_n && !prev.cs_n;

endmodule : spm_pin_sync
`default_nettype wire

// File: rtl/spm_seq_program.sv
// spm_seq_program: serial command handler for sequential byte program mode
`timescale 1ns/1ns
`default_nettype none
module spm_seq_program #(
	parameter int unsigned PROG_CYCLES = spm_pkg::BYTE_PROGRAM_CYCLES,
	parameter logic [7:0]  MFG_ID      = spm_pkg::MFG_ID_DEFAULT,
	parameter logic [7:0]  DEV_ID      = spm_pkg::DEV_ID_DEFAULT,
	parameter logic [23:0] ADDR_LAST   = spm_pkg::ARRAY_LAST_ADDR
) (
	// clock and reset
	input  wire logic               clock_i,
	input  wire logic               reset_i,
	// serial pins
	input  wire spm_pkg::spm_pins_t pins_i,
	output logic                    so_o,
	output logic                    so_oe_o,
	// array program request
	output spm_pkg::spm_prog_t      prog_o,
	output logic                    prog_valid_o,
	// status
	output logic                    write_enable_latch_o,
	output logic                    busy_flag_o,
	output logic                    seq_program_active_flag_o,
	output logic                    cmd_reject_o
);
	import spm_pkg::*;

	spm_pins_t   pins;
	logic        sck_rise;
	logic        sck_fall;
	logic        cs_assert;
	logic        cs_release;
	spm_phase_t  phase;
	logic [2:0]  bit_cnt;
	logic [7:0]  shift_in;
	logic [7:0]  next_byte;
	logic [7:0]  opcode;
	logic [7:0]  data_byte;
	logic [7:0]  reply;
	logic [7:0]  status_reg_one;
	logic [23:0] addr_in;
	logic [23:0] addr_cnt;
	logic [23:0] prog_target;
	logic [1:0]  addr_bytes;
	logic [1:0]  id_idx;
	logic [15:0] timer;
	logic        byte_done;
	logic        data_seen;
	logic        cmd_ok;
	logic        op_allowed;
	logic        reset_armed;
	logic        last_pending;
	logic        frame_whole;
	logic        prog_go;
	logic        seq_abort;
	logic        prog_kill;
	logic        prog_done;
	logic        prog_finish;
	logic        next_wel;
	logic        next_mode;
	logic        next_armed;

	spm_pin_sync u_sync (
		.clock_i      (clock_i),
		.reset_i      (reset_i),
		.pins_i       (pins_i),
		.pins_o       (pins),
		.sck_rise_o   (sck_rise),
		.sck_fall_o   (sck_fall),
		.cs_assert_o  (cs_assert),
		.cs_release_o (cs_release)
	);

	function automatic logic is_seq(input logic [7:0] op);
		return (op == OP_SEQ_A) || (op == OP_SEQ_B);
	endfunction : is_seq

	function automatic logic is_status_read(input logic [7:0] op);
		return (op == OP_RDSR1) || (op == OP_RDSR2) || (op == OP_RDSR3) ||
			(op == OP_RDSR_IND);
	endfunction : is_status_read

	function automatic logic is_id_read(input logic [7:0] op);
		return (op == OP_ID_JEDEC) || (op == OP_ID_MFG) || (op == OP_ID_QUAD);
	endfunction : is_id_read

	function automatic logic is_reset_cmd(input logic [7:0] op);
		return (op == OP_TERMINATE) || (op == OP_RESET_EN) || (op == OP_RESET);
	endfunction : is_reset_cmd

	// which opcodes this block takes; everything else is refused in mode
	function automatic logic cmd_allowed(
		input logic [7:0] op,
		input logic       busy,
		input logic       mode,
		input logic       write_enable_latch
	);
		if (busy)
			return is_status_read(op) || is_reset_cmd(op);
		if (is_seq(op))
			return mode || write_enable_latch;
		return is_status_read(op) || is_id_read(op) || is_reset_cmd(op) ||
			(op == OP_WREN) || (op == OP_WRDI);
	endfunction : cmd_allowed

	function automatic spm_phase_t phase_for(input logic [7:0] op, input logic mode);
		if (is_seq(op))
			return mode ? PH_DATA : PH_ADDR;
		if (is_status_read(op) || is_id_read(op))
			return PH_READ;
		return PH_DROP;
	endfunction : phase_for

	function automatic logic [7:0] reply_for(
		input logic [7:0] op,
		input logic [1:0] idx,
		input logic [7:0] sr1
	);
		if ((op == OP_RDSR1) || (op == OP_RDSR_IND))
			return sr1;
		if (is_id_read(op) && (idx == IDX_MFG))
			return MFG_ID;
		if (is_id_read(op) && (idx == IDX_DEV))
			return DEV_ID;
		return 8'h00;
	endfunction : reply_for

	assign byte_done  = sck_rise && !pins.cs_n && (bit_cnt == BIT_LAST);
	assign next_byte  = {shift_in[6:0], pins.si};
	assign op_allowed = cmd_allowed(next_byte, busy_flag_o, seq_program_active_flag_o,
		write_enable_latch_o);

	always_comb begin
		status_reg_one               = 8'h00;
		status_reg_one[SR1_BUSY_BIT] = busy_flag_o;
		status_reg_one[SR1_WEL_BIT]  = write_enable_latch_o;
	end

	// serial shifter and bit counter
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			shift_in <= 8'h00;
			bit_cnt  <= 3'h0;
		end else if (cs_assert) begin
			bit_cnt <= 3'h0;
		end else if (sck_rise && !pins.cs_n) begin
			shift_in <= next_byte;
			bit_cnt  <= bit_cnt + BIT_STEP;
		end
	end

	// command phase tracking
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			phase        <= PH_OPCODE;
			opcode       <= 8'h00;
			cmd_ok       <= 1'b0;
			cmd_reject_o <= 1'b0;
		end else begin
			cmd_reject_o <= 1'b0;
			if (cs_assert) begin
				phase  <= PH_OPCODE;
				cmd_ok <= 1'b0;
			end else if (byte_done) begin
				unique case (phase)
					PH_OPCODE: begin
						opcode <= next_byte;
						cmd_ok <= op_allowed;
						cmd_reject_o <= !op_allowed &&
							(busy_flag_o || seq_program_active_flag_o);
						phase <= op_allowed ?
							phase_for(next_byte, seq_program_active_flag_o) : PH_DROP;
					end
					PH_ADDR: begin
						if (addr_bytes == ADDR_BYTE_LAST)
							phase <= PH_DATA;
					end
					PH_DATA, PH_READ, PH_DROP: begin
					end
				endcase
			end
		end
	end

	// address and data capture
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			addr_in    <= 24'h000000;
			addr_bytes <= 2'h0;
			data_byte  <= 8'h00;
			data_seen  <= 1'b0;
		end else if (cs_assert) begin
			addr_bytes <= 2'h0;
			data_seen  <= 1'b0;
		end else if (byte_done && (phase == PH_ADDR)) begin
			addr_in    <= {addr_in[15:0], next_byte};
			addr_bytes <= addr_bytes + IDX_STEP;
		end else if (byte_done && (phase == PH_DATA)) begin
			data_byte <= next_byte;
			data_seen <= 1'b1;
		end
	end

	// frame end decisions
	assign frame_whole = cs_release && cmd_ok && (bit_cnt == 3'h0);
	assign prog_go     = frame_whole && is_seq(opcode) && (phase == PH_DATA) && data_seen;
	assign seq_abort   = cs_release && cmd_ok && is_seq(opcode) && !prog_go;
	assign prog_kill   = frame_whole &&
		((opcode == OP_TERMINATE) || ((opcode == OP_RESET) && reset_armed));
	assign prog_target = seq_program_active_flag_o ? addr_cnt : addr_in;
	// last busy cycle, so after the last array byte busy and latch fall together
	assign prog_finish = busy_flag_o && (timer == TIMER_LAST) && !prog_kill && !prog_go;

	always_comb begin
		next_wel   = write_enable_latch_o;
		next_mode  = seq_program_active_flag_o;
		next_armed = reset_armed;
		if (prog_finish && last_pending) begin
			next_wel  = 1'b0;
			next_mode = 1'b0;
		end
		if (cs_release)
			next_armed = frame_whole && (opcode == OP_RESET_EN);
		if (frame_whole && (opcode == OP_WREN))
			next_wel = 1'b1;
		if (frame_whole && (opcode == OP_WRDI))
			next_wel = 1'b0;
		if (prog_kill) begin
			next_wel  = 1'b0;
			next_mode = 1'b0;
		end
		if (prog_go)
			next_mode = 1'b1;
		if (seq_abort)
			next_wel = 1'b0;
		next_mode = next_mode && next_wel;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			write_enable_latch_o      <= 1'b0;
			seq_program_active_flag_o <= 1'b0;
			reset_armed               <= 1'b0;
		end else begin
			write_enable_latch_o      <= next_wel;
			seq_program_active_flag_o <= next_mode;
			reset_armed               <= next_armed;
		end
	end

	// address counter and request
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			addr_cnt     <= 24'h000000;
			last_pending <= 1'b0;
			prog_o       <= '0;
			prog_valid_o <= 1'b0;
		end else begin
			prog_valid_o <= prog_go;
			if (prog_go) begin
				prog_o <= '{addr: prog_target, data: data_byte};
				addr_cnt     <= prog_target + ADDR_STEP;
				last_pending <= (prog_target == ADDR_LAST);
			end else if (prog_kill) begin
				last_pending <= 1'b0;
			end
		end
	end

	// self-timed program
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			timer       <= 16'h0000;
			busy_flag_o <= 1'b0;
			prog_done   <= 1'b0;
		end else begin
			prog_done <= 1'b0;
			if (prog_kill) begin
				timer       <= 16'h0000;
				busy_flag_o <= 1'b0;
			end else if (prog_go) begin
				timer       <= TIMER_W'(PROG_CYCLES);
				busy_flag_o <= 1'b1;
			end else if (busy_flag_o) begin
				timer <= timer - TIMER_STEP;
				if (prog_finish) begin
					busy_flag_o <= 1'b0;
					prog_done   <= 1'b1;
				end
			end
		end
	end

	// read reply bytes
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			reply  <= 8'h00;
			id_idx <= 2'h0;
		end else if (byte_done && (phase == PH_OPCODE)) begin
			reply  <= reply_for(next_byte, IDX_MFG, status_reg_one);
			id_idx <= IDX_DEV;
		end else if (byte_done && (phase == PH_READ)) begin
			reply  <= reply_for(opcode, id_idx, status_reg_one);
			id_idx <= id_idx + IDX_STEP;
		end
	end

	// serial output on falling clock
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			so_o <= 1'b0;
		end else if (cs_release || cs_assert) begin
			so_o <= 1'b0;
		end else if (sck_fall && !pins.cs_n && (phase == PH_READ)) begin
			so_o <= reply[BIT_LAST - bit_cnt];
		end
	end

	assign so_oe_o = (phase == PH_READ) && !pins.cs_n;

	// helper for busy length check
	logic [31:0] busy_run;
	always_ff @(posedge clock_i) begin
		if (reset_i)
			busy_run <= 32'h0000_0000;
		else if (busy_flag_o)
			busy_run <= busy_run + 32'h0000_0001;
		else
			busy_run <= 32'h0000_0000;
	end

	property p_prog_busy;
		@(posedge clock_i) disable iff (reset_i)
		prog_valid_o |-> busy_flag_o && write_enable_latch_o;
	endproperty
	a_prog_busy: assert property (p_prog_busy)
		else $error("program request without busy");

	property p_busy_len;
		@(posedge clock_i) disable iff (reset_i)
		$fell(busy_flag_o) && prog_done |-> busy_run == PROG_CYCLES;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy time differs from program time");

	property p_mode_wel;
		@(posedge clock_i) disable iff (reset_i)
		seq_program_active_flag_o |-> write_enable_latch_o;
	endproperty
	a_mode_wel: assert property (p_mode_wel)
		else $error("mode active without write enable latch");

	property p_addr_step;
		@(posedge clock_i) disable iff (reset_i)
		prog_valid_o |-> addr_cnt == prog_o.addr + ADDR_STEP;
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("address counter did not step");

	property p_wrdi;
		@(posedge clock_i) disable iff (reset_i)
		frame_whole && (opcode == OP_WRDI) |=> !write_enable_latch_o
			&& !seq_program_active_flag_o;
	endproperty
	a_wrdi: assert property (p_wrdi)
		else $error("write disable did not end mode");

	property p_abort;
		@(posedge clock_i) disable iff (reset_i)
		cs_release && cmd_ok && is_seq(opcode) && (bit_cnt != 3'h0)
			|=> !write_enable_latch_o && !prog_valid_o;
	endproperty
	a_abort: assert property (p_abort)
		else $error("broken frame not aborted");

	property p_reject_keeps;
		@(posedge clock_i) disable iff (reset_i)
		cmd_reject_o && !prog_done |-> addr_cnt == $past(addr_cnt)
			&& seq_program_active_flag_o == $past(seq_program_active_flag_o);
	endproperty
	a_reject_keeps: assert property (p_reject_keeps)
		else $error("rejected command changed mode state");

	property p_last;
		@(posedge clock_i) disable iff (reset_i)
		prog_done && last_pending |=> !seq_program_active_flag_o && !write_enable_latch_o;
	endproperty
	a_last: assert property (p_last)
		else $error("mode kept after last array byte");

	property p_refuse;
		@(posedge clock_i) disable iff (reset_i)
		byte_done && (phase == PH_OPCODE) && !op_allowed && seq_program_active_flag_o
			|=> cmd_reject_o && !cmd_ok ##1 !cmd_reject_o;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("refused command not flagged");

endmodule : spm_seq_program
`default_nettype wire

// File: testbench/spm_host_model.sv
// spm_host_model: host side serial controller issuing flash command frames
`timescale 1ns/1ns
`default_nettype none
module spm_host_model (
	// clock
	input  wire logic               clock_i,
	// serial pins
	input  wire logic               so_i,
	output var spm_pkg::spm_pins_t  pins_o
);
	import spm_pkg::*;

	initial pins_o = PINS_IDLE;

	// sck 80 ns, mode 0, data set while sck low
	task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
		rx = '0;
		@(posedge clock_i);
		pins_o.cs_n <= 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			pins_o.si  <= tx[i];
			pins_o.sck <= 1'b0;
			repeat (4) @(posedge clock_i);
			rx = {rx[62:0], so_i};
			pins_o.sck <= 1'b1;
			repeat (4) @(posedge clock_i);
		end
		pins_o.sck <= 1'b0;
		repeat (4) @(posedge clock_i);
		pins_o.cs_n <= 1'b1;
		// idle si toggles so no stale level survives
		repeat (6) begin
			@(posedge clock_i);
			pins_o.si <= ~pins_o.si;
		end
	endtask : frame
endmodule : spm_host_model
`default_nettype wire

// File: testbench/spm_seq_program_tb.sv
// spm_seq_program_tb: self-checking bench for sequential byte program mode
`timescale 1ns/1ns
`default_nettype none
module spm_seq_program_tb;
	import spm_pkg::*;

	localparam int unsigned PROG = 400;

	logic        clock_i;
	logic        reset_i = 1'b1;
	spm_pins_t   pins;
	spm_prog_t   prog;
	logic        so, so_oe, pv, write_enable_latch, busy, mode, rej;
	logic        exp_wel, exp_mode;
	logic [23:0] ctr, addr;
	logic [7:0]  d;
	logic [63:0] rx;
	logic [31:0] exp_q[$];
	int          errors, total_checks, rej_cnt, rej_exp, busy_cnt, busy_len, seed;
	logic [7:0]  bad_ops[13] = '{8'h03, 8'h20, 8'h60, 8'h02, 8'hB0, 8'h75, 8'hD0,
		8'h36, 8'h7E, 8'h3C, 8'h01, 8'h71, 8'h6F};
	logic [7:0]  id_ops[3] = '{OP_ID_JEDEC, OP_ID_MFG, OP_ID_QUAD};

	spm_seq_program #(.PROG_CYCLES(PROG)) dut_u (
		.clock_i                   (clock_i),
		.reset_i                   (reset_i),
		.pins_i                    (pins),
		.so_o                      (so),
		.so_oe_o                   (so_oe),
		.prog_o                    (prog),
		.prog_valid_o              (pv),
		.write_enable_latch_o      (write_enable_latch),
		.busy_flag_o               (busy),
		.seq_program_active_flag_o (mode),
		.cmd_reject_o              (rej)
	);

	spm_host_model host_u (
		.clock_i (clock_i),
		.so_i    (so),
		.pins_o  (pins)
	);

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	// refusal pulses, busy length and program requests
	always @(posedge clock_i) begin
		if (rej === 1'b1)
			rej_cnt++;
		if (busy === 1'b1)
			busy_cnt++;
		else if (busy_cnt != 0) begin
			busy_len = busy_cnt;
			busy_cnt = 0;
		end
		if (pv === 1'b1)
			chk(prog, exp_q.size() != 0 ? exp_q.pop_front() : ~prog);
	end

	task automatic xfer(input logic [63:0] tx, input int n);
		host_u.frame(tx, n, rx);
	endtask : xfer

	task automatic chk_flags;
		repeat (2) @(posedge clock_i);
		chk({30'h0, write_enable_latch, mode}, {30'h0, exp_wel, exp_mode});
	endtask : chk_flags

	task automatic wait_idle;
		int n;
		n = 0;
		rx = 64'h1;
		while (rx[0] !== 1'b0 && n < 100) begin
			xfer({OP_RDSR1, 8'h00}, 16);
			n++;
		end
		if (n >= 100) begin
			errors++;
			wrap_up;
		end
		chk(rx[7:0], {6'h0, exp_wel, 1'b0});
		chk(busy_len, PROG);
		chk(exp_q.size(), 0);
	endtask : wait_idle

	task automatic enter(input logic [23:0] a);
		d = 8'($random(seed));
		xfer(OP_WREN, 8);
		exp_wel = 1'b1;
		exp_q.push_back({a, d});
		xfer({OP_SEQ_A, a, d}, 40);
		exp_mode = 1'b1;
		ctr = a + 24'h000001;
	endtask : enter

	initial begin
		seed = 32'h2505b550;
		repeat (8) @(posedge clock_i);
		reset_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		chk({26'h0, write_enable_latch, busy, mode, pv, rej, so_oe}, 32'h0);
		$display("test reset done");

		// fresh addresses each entry, all taken as erased
		addr = 24'($random(seed)) & 24'h03FC00;
		enter(addr);
		chk_flags;
		xfer(OP_WREN, 8);
		rej_exp++;
		wait_idle;
		chk(rej_cnt, rej_exp);
		$display("test entry done");

		foreach (bad_ops[i]) begin
			xfer(bad_ops[i], 8);
			rej_exp++;
		end
		chk(rej_cnt, rej_exp);
		chk_flags;
		foreach (id_ops[i]) begin
			xfer({id_ops[i], 16'h0000}, 24);
			chk(rx[15:0], {MFG_ID_DEFAULT, DEV_ID_DEFAULT});
		end
		xfer({OP_RDSR_IND, 8'h00}, 16);
		chk(rx[7:0], 8'h02);
		xfer({OP_RDSR2, 8'h00}, 16);
		chk(rx[7:0], 8'h00);
		xfer({OP_RDSR3, 8'h00}, 16);
		chk(rx[7:0], 8'h00);
		chk(rej_cnt, rej_exp);
		$display("test command table done");

		for (int k = 0; k < 2; k++) begin
			d = 8'($random(seed));
			exp_q.push_back({ctr, d});
			xfer({(k == 0) ? OP_SEQ_B : OP_SEQ_A, 8'h5C, d}, 24);
			ctr = ctr + 24'h000001;
			wait_idle;
		end
		$display("test subsequent done");

		xfer({OP_SEQ_B, 4'hA}, 12);
		exp_wel = 1'b0;
		exp_mode = 1'b0;
		repeat (10) @(posedge clock_i);
		chk_flags;
		$display("test abort done");

		for (int k = 0; k < 3; k++) begin
			enter(addr + 24'(24'h000100 * (k + 1)));
			wait_idle;
			if (k == 0)
				xfer(OP_WRDI, 8);
			else if (k == 1)
				xfer(OP_TERMINATE, 8);
			else begin
				xfer(OP_RESET_EN, 8);
				xfer(OP_RESET, 8);
			end
			exp_wel = 1'b0;
			exp_mode = 1'b0;
			chk_flags;
		end
		$display("test endings done");

		enter(ARRAY_LAST_ADDR);
		exp_wel = 1'b0;
		exp_mode = 1'b0;
		wait_idle;
		chk_flags;
		$display("test last address done");
		wrap_up;
	end

	initial begin
		repeat (100000) @(posedge clock_i);
		errors++;
		wrap_up;
	end
endmodule : spm_seq_program_tb
`default_nettype wire
